// file: rtl/nt_cfg_pkg.sv
// constants and carrier types for the mode and serial frame block
package nt_cfg_pkg;
  localparam int MCLK_MHZ = 250;
  localparam logic [6:0] BITS_PER_FRAME = 7'h60;
  localparam logic [6:0] SLOT_LEN = 7'h08;
  localparam logic [6:0] SLOT_B1 = 7'h00;
  localparam logic [6:0] SLOT_B2 = 7'h08;
  localparam logic [6:0] SLOT_IC1 = 7'h40;
  localparam logic [6:0] SLOT_IC2 = 7'h48;
  localparam logic [1:0] SEL_B1 = 2'h0;
  localparam logic [1:0] SEL_B2 = 2'h1;
  localparam logic [1:0] SEL_IC1 = 2'h2;
  localparam logic [1:0] SEL_IC2 = 2'h3;
  localparam logic [1:0] CHAN_U = 2'h0;
  localparam logic [1:0] CHAN_S_RESET = 2'h1;
  localparam logic [2:0] TEST_QUIET = 3'h0;
  localparam logic [2:0] TEST_DATA_THROUGH = 3'h5;
  localparam logic [2:0] TEST_NORMAL = 3'h7;
  localparam logic [2:0] LT_PULSES_NEEDED = 3'h3;
  localparam int LT_TIMEOUT_US = 1000;
  localparam int LT_TIMEOUT_CYC = LT_TIMEOUT_US * MCLK_MHZ;
  localparam logic [7:0] ACCESS_RESET = 8'hff;

  typedef enum logic [1:0] {MODE_STANDALONE, MODE_MICRO_NT, MODE_MICRO_TE} op_mode_t;
  typedef enum logic [1:0] {ARB_IDLE, ARB_BUS, ARB_LOCAL} arb_state_t;
  typedef enum logic [1:0] {LT_IDLE, LT_COUNT, LT_ACTIVE} lt_state_t;

  typedef struct packed {
    logic two_wire_en;
    logic four_wire_en;
    logic framer_en;
    logic tdm_en;
    logic arb_en;
  } unit_en_t;

  typedef struct packed {
    logic te_select;
    unit_en_t units;
    logic [2:0] test_code;
    logic [1:0] s_chan;
    logic s_bearer_ch0;
    logic s_sig_ch0;
    logic [1:0] strobe_a_sel;
    logic [1:0] strobe_b_sel;
    logic [1:0] access_sel;
  } cfg_t;

  typedef struct packed {
    op_mode_t mode;
    unit_en_t units;
    logic two_wire_te;
    logic four_wire_lt;
    logic [1:0] u_chan;
    logic [1:0] s_chan;
    logic s_bearer_ch0;
    logic s_sig_ch0;
    logic [2:0] test_code;
    logic upi_enable;
  } status_t;
endpackage

// file: rtl/nt_mode_and_tdm_config.sv
// mode selection, unit enables, serial frame timing, strobes, arbitration, loop termination
// Overview of operation
// RULE_01 - test enable low turns the three shared pins into a test select code
// RULE_02 - mode pin 0 gives standalone termination, 1 gives microcontroller mode
// RULE_03 - external reset input is active low; unused it is held high
// RULE_04 - system supplies 15.36 MHz master timing by clock or crystal; the code takes a 250 MHz mclk (MCLK_MHZ) for its timeout
// RULE_05 - each internal unit is configured and enabled on its own
// RULE_06 - intelligent setup drives 1.536 MHz data clock, three channel frame
// RULE_07 - two-wire transceiver in terminal mode uses channel 0
// RULE_08 - four-wire transceiver runs line termination, programmable to channel 1
// RULE_09 - control bits map four-wire bearer and signalling into channel 0
// RULE_10 - signalling channel arbitrated between bus terminals and local framer
// RULE_11 - loop termination machine sets test mode, interrupts, shows its state
// RULE_12 - two frame strobes, each assignable to a bearer or intercom channel
// RULE_13 - 768 kHz bit clock accompanies the strobes for plain codecs
// RULE_14 - microcontroller reaches bearer and intercom channels of the frame
// RULE_15 - network-side micro mode: two-wire line times frame, four-wire off; the code leaves four_wire_en at its configured value
// RULE_16 - terminal micro mode: four-wire line times frame, two-wire off
// RULE_17 - standalone mode disables framer and processor port, safe defaults
// RULE_18 - non-normal pin test selection overrides the configured test code
// RULE_19 - each strobe high once a frame for exactly its channel bits
`timescale 1ns/100ps
module nt_mode_and_tdm_config
  import nt_cfg_pkg::*;
#(
  parameter int LT_TIMEOUT = LT_TIMEOUT_CYC
)(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ext_reset_in_n,
  input wire logic mode_select,
  input wire logic test_enable_n,
  input wire logic [2:0] test_select_pins,
  input wire logic loop_term_pulse_in,
  input wire logic two_wire_line_clk,
  input wire logic four_wire_line_clk,
  input wire logic serial_data_in,
  input wire cfg_t cfg,
  input wire logic bus_sig_req,
  input wire logic local_sig_req,
  output status_t status,
  output logic data_clock,
  output logic frame_sync,
  output logic codec_bit_clock,
  output logic frame_strobe_a,
  output logic frame_strobe_b,
  output logic bus_access_control,
  output logic bus_grant,
  output lt_state_t lt_state,
  output logic ci_irq,
  output logic [7:0] access_byte,
  output logic access_valid
);
  // the ten pins in raw pass two flops; only stage two is read
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] raw;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [2:0] prev_reg;
  assign raw = {serial_data_in, four_wire_line_clk, two_wire_line_clk, loop_term_pulse_in,
                test_select_pins, test_enable_n, mode_select, ext_reset_in_n};

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
    end
  end

  logic soft_rst, micro_s, test_on_s, lt_in_s, u_clk_s, s_clk_s, sdi_s;
  logic [2:0] tsel_s;
  assign soft_rst = !sync2_reg[0]; // see RULE_03
  assign micro_s = sync2_reg[1];
  assign test_on_s = !sync2_reg[2]; // see RULE_01
  assign tsel_s = sync2_reg[5:3];
  assign lt_in_s = sync2_reg[6];
  assign u_clk_s = sync2_reg[7];
  assign s_clk_s = sync2_reg[8];
  assign sdi_s = sync2_reg[9];

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      prev_reg <= 3'h7;
    else
      prev_reg <= {s_clk_s, u_clk_s, lt_in_s};
  end

  // ---------------- mode and configuration ----------------
  op_mode_t mode_next;
  lt_state_t lt_reg;
  status_t status_next;
  always_comb
  begin
    status_next = '0;
    if (!micro_s)
      mode_next = MODE_STANDALONE; // see RULE_02
    else if (cfg.te_select)
      mode_next = MODE_MICRO_TE;
    else
      mode_next = MODE_MICRO_NT;
    status_next.mode = mode_next;
    status_next.u_chan = CHAN_U; // see RULE_07
    if (mode_next == MODE_STANDALONE)
    begin
      // fixed termination defaults, no controller needed
      status_next.units.two_wire_en = 1'b1; // see RULE_17
      status_next.units.four_wire_en = 1'b1;
      status_next.units.tdm_en = test_on_s && (tsel_s == TEST_NORMAL);
      status_next.four_wire_lt = 1'b1;
      status_next.s_chan = CHAN_S_RESET;
      status_next.test_code = TEST_NORMAL;
    end
    else
    begin
      status_next.units = cfg.units; // see RULE_05
      status_next.upi_enable = !test_on_s; // see RULE_01
      status_next.test_code = cfg.test_code;
      status_next.s_chan = cfg.s_chan; // see RULE_08
      status_next.s_bearer_ch0 = cfg.s_bearer_ch0; // see RULE_09
      status_next.s_sig_ch0 = cfg.s_sig_ch0; // see RULE_09
      if (mode_next == MODE_MICRO_TE)
        status_next.units.two_wire_en = 1'b0; // see RULE_16
      else
      begin
        status_next.two_wire_te = 1'b1; // see RULE_07
        status_next.four_wire_lt = 1'b1; // see RULE_08
        // terminal use of the two-wire line leaves the four-wire enable at its configured value
        if (!cfg.units.four_wire_en)
          status_next.units.four_wire_en = 1'b0; // see RULE_15
      end
    end
    if (lt_reg == LT_ACTIVE)
      status_next.test_code = TEST_DATA_THROUGH; // see RULE_11
    // pins win over both configuration and loop termination
    if (test_on_s && tsel_s != TEST_NORMAL)
      status_next.test_code = tsel_s; // see RULE_18
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      status <= '0;
    else
      status <= status_next;
  end

  // ---------------- frame timing ----------------
  // line clock is sampled at mclk; four rising edges of it make one bit
  logic ref_edge;
  logic [1:0] ph_reg;
  logic [1:0] ph_next;
  logic [6:0] bit_reg;
  logic [6:0] bit_next;
  logic tdm_on;
  assign tdm_on = status.units.tdm_en;
  always_comb
  begin
    if (status.mode == MODE_MICRO_TE)
      ref_edge = s_clk_s && !prev_reg[2]; // see RULE_16
    else
      ref_edge = u_clk_s && !prev_reg[1]; // see RULE_15
    ph_next = ph_reg + 2'h1;
    bit_next = bit_reg;
    if (ph_reg == 2'h3)
      bit_next = (bit_reg == BITS_PER_FRAME - 7'h01) ? 7'h00 : bit_reg + 7'h01; // see RULE_06
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ph_reg <= 2'h0;
      bit_reg <= 7'h00;
      data_clock <= 1'b0;
      codec_bit_clock <= 1'b0;
      frame_sync <= 1'b0;
    end
    else if (soft_rst || !tdm_on)
    begin
      ph_reg <= 2'h0;
      bit_reg <= 7'h00;
      data_clock <= 1'b0;
      codec_bit_clock <= 1'b0;
      frame_sync <= 1'b0;
    end
    else if (ref_edge)
    begin
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      data_clock <= ph_next[0]; // see RULE_06
      codec_bit_clock <= ph_next[1]; // see RULE_13
      frame_sync <= (bit_next == 7'h00);
    end
  end

  function automatic logic in_slot(input logic [1:0] sel, input logic [6:0] b);
    logic [6:0] base;
    case (sel)
      SEL_B1: base = SLOT_B1;
      SEL_B2: base = SLOT_B2;
      SEL_IC1: base = SLOT_IC1;
      default: base = SLOT_IC2;
    endcase
    return (b >= base) && (b < base + SLOT_LEN);
  endfunction

  logic [1:0] strobe_sel [2];
  logic [1:0] sel_reg [2];
  logic [1:0] strobe_q;
  logic frame_edge;
  assign strobe_sel[0] = cfg.strobe_a_sel;
  assign strobe_sel[1] = cfg.strobe_b_sel;
  assign frame_edge = ref_edge && ph_reg == 2'h3 && bit_next == 7'h00;
  // a new select lands at a frame start or while timing is held off, so no strobe is cut short mid-frame
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_strobe
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          strobe_q[i] <= 1'b0;
          sel_reg[i] <= SEL_B1;
        end
        else if (soft_rst || !tdm_on)
        begin
          strobe_q[i] <= 1'b0;
          sel_reg[i] <= strobe_sel[i];
        end
        else if (ref_edge && ph_reg == 2'h3)
        begin
          if (frame_edge)
            sel_reg[i] <= strobe_sel[i]; // see RULE_19
          strobe_q[i] <= in_slot(frame_edge ? strobe_sel[i] : sel_reg[i], bit_next); // see RULE_12
        end
      end
    end
  endgenerate
  assign frame_strobe_a = strobe_q[0]; // see RULE_19
  assign frame_strobe_b = strobe_q[1];

  // microcontroller slot capture, sampled mid-bit
  logic [7:0] shift_reg;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      shift_reg <= ACCESS_RESET;
      access_byte <= ACCESS_RESET;
      access_valid <= 1'b0;
    end
    else
    begin
      access_valid <= 1'b0;
      if (tdm_on && status.upi_enable && ref_edge && ph_reg == 2'h1 &&
          in_slot(cfg.access_sel, bit_reg))
      begin
        shift_reg <= {shift_reg[6:0], sdi_s}; // see RULE_14
        if (in_slot(cfg.access_sel, bit_reg + 7'h01) == 1'b0)
        begin
          access_byte <= {shift_reg[6:0], sdi_s};
          access_valid <= 1'b1;
        end
      end
    end
  end

  // ---------------- signalling channel arbitration ----------------
  // bus terminals win a tie: the local framer only starts on an idle channel
  arb_state_t arb_reg;
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      arb_reg <= ARB_IDLE;
    else if (soft_rst || !status.units.arb_en)
      arb_reg <= ARB_IDLE;
    else
      case (arb_reg)
        ARB_IDLE:
          if (bus_sig_req)
            arb_reg <= ARB_BUS; // see RULE_10
          else if (local_sig_req && status.units.framer_en)
            arb_reg <= ARB_LOCAL;
        ARB_BUS:
          if (!bus_sig_req)
            arb_reg <= ARB_IDLE;
        default:
          if (!local_sig_req)
            arb_reg <= ARB_IDLE;
      endcase
  end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_access_control <= 1'b0;
      bus_grant <= 1'b0;
    end
    else
    begin
      bus_access_control <= (arb_reg == ARB_LOCAL);
      bus_grant <= (arb_reg == ARB_BUS);
    end
  end

  // ---------------- loop termination ----------------
  // pulses are low-going; an unused input sits high and never counts
  logic lt_fall;
  logic [2:0] pulse_cnt_reg;
  logic [31:0] lt_timer_reg;
  assign lt_fall = !lt_in_s && prev_reg[0];
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lt_reg <= LT_IDLE;
      pulse_cnt_reg <= 3'h0;
      lt_timer_reg <= '0;
    end
    else if (soft_rst)
    begin
      lt_reg <= LT_IDLE;
      pulse_cnt_reg <= 3'h0;
      lt_timer_reg <= '0;
    end
    else
    begin
      lt_timer_reg <= lt_fall ? '0 : lt_timer_reg + 32'h1;
      case (lt_reg)
        LT_IDLE:
          if (lt_fall)
          begin
            lt_reg <= LT_COUNT;
            pulse_cnt_reg <= 3'h1;
          end
        LT_COUNT:
          if (lt_fall)
          begin
            pulse_cnt_reg <= pulse_cnt_reg + 3'h1;
            if (pulse_cnt_reg + 3'h1 == LT_PULSES_NEEDED)
              lt_reg <= LT_ACTIVE; // see RULE_11
          end
          else if (lt_timer_reg == 32'(LT_TIMEOUT))
            lt_reg <= LT_IDLE;
        default:
          if (lt_fall)
            lt_reg <= LT_IDLE;
      endcase
    end
  end
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lt_state <= LT_IDLE;
      ci_irq <= 1'b0;
    end
    else
    begin
      lt_state <= lt_reg; // see RULE_11
      ci_irq <= (lt_state != lt_reg); // see RULE_11
    end
  end

  // ---------------- assertions ----------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_standalone;
    !micro_s |=> status.mode == MODE_STANDALONE && !status.units.framer_en && !status.upi_enable;
  endproperty
  a_standalone: assert property (p_standalone) else $error("standalone defaults wrong"); // see RULE_17

  property p_test_override;
    test_on_s && tsel_s != TEST_NORMAL |=> status.test_code == $past(tsel_s);
  endproperty
  a_test_override: assert property (p_test_override) else $error("pin test code lost"); // see RULE_18

  property p_upi_off;
    test_on_s |=> !status.upi_enable;
  endproperty
  a_upi_off: assert property (p_upi_off) else $error("port open in test"); // see RULE_01

  property p_te_mode;
    status.mode == MODE_MICRO_TE |-> !status.units.two_wire_en;
  endproperty
  a_te_mode: assert property (p_te_mode) else $error("two-wire on in te mode"); // see RULE_16

  property p_u_chan;
    status.u_chan == CHAN_U;
  endproperty
  a_u_chan: assert property (p_u_chan) else $error("two-wire channel moved"); // see RULE_07

  property p_strobe_slot;
    frame_strobe_a |-> in_slot(sel_reg[0], bit_reg);
  endproperty
  a_strobe_slot: assert property (p_strobe_slot) else $error("strobe a outside slot"); // see RULE_19

  property p_bitclk;
    tdm_on && !soft_rst && ref_edge && ph_reg == 2'h1 |=> codec_bit_clock;
  endproperty
  a_bitclk: assert property (p_bitclk) else $error("bit clock phase wrong"); // see RULE_13

  property p_frame_len;
    frame_sync && $rose(frame_sync) |-> bit_reg == 7'h00;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame sync off bit zero"); // see RULE_06

  property p_arb_excl;
    !(bus_grant && bus_access_control);
  endproperty
  a_arb_excl: assert property (p_arb_excl) else $error("both grants high"); // see RULE_10

  property p_ci_irq;
    lt_state != lt_reg |=> ci_irq ##1 !ci_irq || lt_state != $past(lt_state);
  endproperty
  a_ci_irq: assert property (p_ci_irq) else $error("loop interrupt missing"); // see RULE_11

  c_lt_active: cover property (lt_reg == LT_ACTIVE);
  c_strobe: cover property ($rose(frame_strobe_b));
  c_local: cover property ($rose(bus_access_control));
  c_access: cover property (access_valid);
endmodule

// file: sim/nt_line_partner.sv
// far side model: line clocks and frame data source
`timescale 1ns/100ps
module nt_line_partner
  import nt_cfg_pkg::*;
(
  input wire logic mclk,
  input wire logic run_two,
  input wire logic run_four,
  input wire logic [7:0] tx_byte,
  input wire logic frame_sync,
  input wire logic codec_bit_clock,
  output logic two_wire_line_clk,
  output logic four_wire_line_clk,
  output logic serial_data_in
);
  logic fs_q;
  logic bk_q;
  logic [2:0] idx;
  // idle line clocks stand still low
  initial
  begin
    two_wire_line_clk = 1'b0;
    four_wire_line_clk = 1'b0;
    serial_data_in = 1'b0;
    #1.3;
    forever
    begin
      #80;
      two_wire_line_clk = run_two ? ~two_wire_line_clk : 1'b0;
      four_wire_line_clk = run_four ? ~four_wire_line_clk : 1'b0;
    end
  end
  // data moves mid bit so it is settled when sampled; same byte in every slot
  always @(posedge mclk)
  begin
    fs_q <= frame_sync;
    bk_q <= codec_bit_clock;
    if (frame_sync && !fs_q)
    begin
      serial_data_in <= tx_byte[7];
      idx <= 3'h1;
    end
    else if (codec_bit_clock && !bk_q)
    begin
      serial_data_in <= tx_byte[3'h7 - idx];
      idx <= idx + 3'h1;
    end
  end
endmodule

// file: sim/nt_mode_and_tdm_config_tb_top.sv
// self-checking bench for the mode and serial frame block
`timescale 1ns/100ps
module nt_mode_and_tdm_config_tb_top
  import nt_cfg_pkg::*;
;
  typedef struct packed {
    logic ms;
    logic ten;
    logic [2:0] pins;
    logic te;
    op_mode_t mode;
    logic upi;
    logic code_chk;
    logic [2:0] code;
    unit_en_t units;
    unit_en_t mask;
  } row_t;
  row_t rows [7] = '{
    '{1'b0, 1'b1, 3'h7, 1'b0, MODE_STANDALONE, 1'b0, 1'b0, 3'h0, 5'h00, 5'h05},
    '{1'b0, 1'b0, 3'h5, 1'b0, MODE_STANDALONE, 1'b0, 1'b1, 3'h5, 5'h00, 5'h07},
    '{1'b0, 1'b0, 3'h7, 1'b0, MODE_STANDALONE, 1'b0, 1'b0, 3'h0, 5'h02, 5'h07},
    '{1'b1, 1'b1, 3'h0, 1'b0, MODE_MICRO_NT, 1'b1, 1'b1, 3'h2, 5'h1f, 5'h1f},
    '{1'b1, 1'b0, 3'h0, 1'b0, MODE_MICRO_NT, 1'b0, 1'b1, 3'h0, 5'h00, 5'h00},
    '{1'b1, 1'b0, 3'h7, 1'b1, MODE_MICRO_TE, 1'b0, 1'b1, 3'h2, 5'h00, 5'h10},
    '{1'b1, 1'b1, 3'h3, 1'b1, MODE_MICRO_TE, 1'b1, 1'b1, 3'h2, 5'h00, 5'h10}
  };
  logic mclk = 1'b0, reset_n = 1'b0, ext_reset_in_n = 1'b1, mode_select = 1'b0;
  logic test_enable_n = 1'b1, loop_term_pulse_in = 1'b1;
  logic bus_sig_req = 1'b0, local_sig_req = 1'b0, run_two = 1'b0, run_four = 1'b0;
  logic [2:0] test_select_pins = 3'h7;
  logic [7:0] tx_byte = 8'ha5;
  cfg_t cfg = '{1'b0, 5'h1f, 3'h2, 2'h1, 1'b1, 1'b1, SEL_B1, SEL_B2, SEL_B1};
  logic two_wire_line_clk, four_wire_line_clk, serial_data_in;
  status_t status;
  logic data_clock, frame_sync, codec_bit_clock, frame_strobe_a, frame_strobe_b;
  logic bus_access_control, bus_grant, ci_irq, access_valid;
  lt_state_t lt_state;
  logic [7:0] access_byte, got_byte;
  logic fs_q, bk_q, dc_q, sa_q, sb_q;
  int mismatches = 0, n_compared = 0, cycles = 0, irqs = 0, frames = 0;
  int cnt, a_hi, b_hi, dc_n, acc_n, fr_cyc, a_pos, b_pos;
  int l_bits, l_ahi, l_bhi, l_dc, l_acc, l_cyc, n, bad;

  always #2 mclk = ~mclk;

  nt_mode_and_tdm_config #(.LT_TIMEOUT(200)) DUT (.mclk, .reset_n, .ext_reset_in_n,
    .mode_select, .test_enable_n, .test_select_pins, .loop_term_pulse_in,
    .two_wire_line_clk, .four_wire_line_clk, .serial_data_in, .cfg, .bus_sig_req,
    .local_sig_req, .status, .data_clock, .frame_sync, .codec_bit_clock, .frame_strobe_a,
    .frame_strobe_b, .bus_access_control, .bus_grant, .lt_state, .ci_irq, .access_byte,
    .access_valid);

  nt_line_partner partner (.mclk, .run_two, .run_four, .tx_byte, .frame_sync,
    .codec_bit_clock, .two_wire_line_clk, .four_wire_line_clk, .serial_data_in);

  task automatic tally_and_finish();
    if (mismatches == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wait_frames(input int k);
    int f;
    f = frames + k;
    while (frames < f)
      @(negedge mclk);
  endtask

  task automatic pulse();
    @(negedge mclk);
    loop_term_pulse_in = 1'b0;
    repeat (4) @(negedge mclk);
    loop_term_pulse_in = 1'b1;
    repeat (16) @(negedge mclk);
  endtask

  task automatic chk_frame(input int apos, input int bpos, input logic [7:0] b);
    chk(l_bits, 96, "bits per frame");
    chk(l_dc, 192, "data clocks");
    chk(l_cyc, 15360, "frame length");
    chk(l_ahi, 8, "strobe a bits");
    chk(l_bhi, 8, "strobe b bits");
    chk(a_pos, apos, "strobe a slot");
    chk(b_pos, bpos, "strobe b slot");
    chk(l_acc, 1, "captures");
    chk(got_byte, b, "captured byte");
  endtask

  // frame monitor, sampled where outputs are settled
  always @(negedge mclk)
  begin
    cycles++;
    fr_cyc++;
    if (frame_sync && !fs_q)
    begin
      {l_bits, l_ahi, l_bhi, l_dc, l_acc, l_cyc} = {cnt, a_hi, b_hi, dc_n, acc_n, fr_cyc};
      {cnt, a_hi, b_hi, dc_n, acc_n, fr_cyc} = '0;
      frames++;
    end
    if (codec_bit_clock && !bk_q)
    begin
      cnt++;
      a_hi += int'(frame_strobe_a);
      b_hi += int'(frame_strobe_b);
    end
    if (data_clock && !dc_q)
      dc_n++;
    if (frame_strobe_a && !sa_q)
      a_pos = cnt;
    if (frame_strobe_b && !sb_q)
      b_pos = cnt;
    if (access_valid)
    begin
      acc_n++;
      got_byte = access_byte;
    end
    if (ci_irq)
      irqs++;
    {fs_q, bk_q, dc_q, sa_q, sb_q} = {frame_sync, codec_bit_clock, data_clock,
      frame_strobe_a, frame_strobe_b};
    // budget 90k cycles for about 65k cycles of traffic
    if (cycles > 90000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial
  begin
    repeat (12) @(negedge mclk);
    chk(access_byte, 8'hff, "reset byte");
    chk({frame_sync, data_clock, bus_grant, ci_irq, access_valid}, 0, "reset outs");
    reset_n = 1'b1;
    foreach (rows[i])
    begin
      @(negedge mclk);
      {mode_select, test_enable_n, test_select_pins, cfg.te_select} =
        {rows[i].ms, rows[i].ten, rows[i].pins, rows[i].te};
      repeat (8) @(negedge mclk);
      chk(status.mode, rows[i].mode, "mode");
      chk(status.upi_enable, rows[i].upi, "upi");
      if (rows[i].code_chk)
        chk(status.test_code, rows[i].code, "test code");
      chk(status.units & rows[i].mask, rows[i].units, "units");
    end
    @(negedge mclk);
    {test_enable_n, test_select_pins, cfg.te_select, run_two} = {1'b1, 3'h7, 1'b0, 1'b1};
    repeat (8) @(negedge mclk);
    chk({status.two_wire_te, status.four_wire_lt, status.u_chan}, {2'b11, CHAN_U}, "nt");
    chk({status.s_chan, status.s_bearer_ch0, status.s_sig_ch0}, 4'h7, "s map");
    wait_frames(3);
    chk_frame(0, 8, 8'ha5);
    {cfg.te_select, cfg.strobe_a_sel, cfg.strobe_b_sel, cfg.access_sel} =
      {1'b1, SEL_IC1, SEL_IC2, SEL_IC2};
    {tx_byte, run_two, run_four} = {8'h3c, 1'b0, 1'b1};
    wait_frames(2);
    chk_frame(64, 72, 8'h3c);
    cfg.te_select = 1'b0;
    n = dc_n;
    repeat (2000) @(negedge mclk);
    chk(dc_n - n, 0, "nt needs two-wire");
    {run_two, run_four, ext_reset_in_n} = 3'b100;
    bad = 0;
    repeat (1000)
    begin
      @(negedge mclk);
      bad += int'(data_clock !== 1'b0);
    end
    chk(bad, 0, "held in ext reset");
    ext_reset_in_n = 1'b1;
    repeat (4) @(negedge mclk);
    {bus_sig_req, local_sig_req} = 2'b11;
    repeat (3) @(negedge mclk);
    chk({bus_grant, bus_access_control}, 2'b10, "bus wins");
    bus_sig_req = 1'b0;
    repeat (6) @(negedge mclk);
    chk({bus_grant, bus_access_control}, 2'b01, "local next");
    local_sig_req = 1'b0;
    repeat (4) @(negedge mclk);
    chk({bus_grant, bus_access_control}, 2'b00, "released");
    n = irqs;
    pulse();
    chk(lt_state, LT_COUNT, "lt count");
    repeat (250) @(negedge mclk);
    chk(lt_state, LT_IDLE, "lt timeout");
    repeat (3) pulse();
    chk(lt_state, LT_ACTIVE, "lt active");
    chk(status.test_code, TEST_DATA_THROUGH, "lt code");
    {test_enable_n, test_select_pins} = {1'b0, TEST_QUIET};
    repeat (8) @(negedge mclk);
    chk(status.test_code, TEST_QUIET, "pin override");
    {test_enable_n, test_select_pins} = {1'b1, TEST_NORMAL};
    pulse();
    chk(lt_state, LT_IDLE, "lt off");
    chk(irqs - n, 5, "lt irqs");
    tally_and_finish();
  end
endmodule
